// ### core/adcsf_defs.svh
`ifndef ADCSF_DEFS_SVH
`define ADCSF_DEFS_SVH

// ****************************************
// Sizes
// ****************************************
`define ADCSF_NCH 8
`define ADCSF_CHW 3
`define ADCSF_DW 10
`define ADCSF_AW 8

// ****************************************
// Register byte offsets
// ****************************************
`define ADCSF_CTRL_OFS 8'h00
`define ADCSF_MODE_OFS 8'h04
`define ADCSF_CHEN_OFS 8'h10
`define ADCSF_CHDIS_OFS 8'h14
`define ADCSF_CHSTAT_OFS 8'h18
`define ADCSF_STAT_OFS 8'h1c
`define ADCSF_LAST_OFS 8'h20
`define ADCSF_IRQ_STAT_OFS 8'h28
`define ADCSF_IRQ_MASK_OFS 8'h2c
`define ADCSF_CDR_BASE_OFS 8'h40

// ****************************************
// Field positions
// ****************************************
`define ADCSF_CTRL_START_BIT 0
`define ADCSF_MODE_SLEEP_BIT 0
`define ADCSF_STAT_CHOVR_LSB 8
`define ADCSF_STAT_READY_BIT 16
`define ADCSF_STAT_GLOVR_BIT 17
`define ADCSF_LAST_CH_LSB 16
`define ADCSF_EVT_EOC_BIT 0
`define ADCSF_EVT_READY_BIT 1
`define ADCSF_EVT_CHOVR_BIT 2
`define ADCSF_EVT_GLOVR_BIT 3
`define ADCSF_NEVT 4

// ****************************************
// Reset values
// ****************************************
`define ADCSF_CHEN_RST 8'h00
`define ADCSF_MASK_RST 4'h0

`endif

// ### core/adcsf_pkg.sv
package adcsf_pkg;
  `include "adcsf_defs.svh"

  // ****************************************
  // Types
  // ****************************************
  typedef logic [`ADCSF_NCH-1:0] adcsf_chmask_t;
  typedef logic [`ADCSF_CHW-1:0] adcsf_chan_t;
  typedef logic [`ADCSF_DW-1:0] adcsf_data_t;
  typedef logic [`ADCSF_AW-1:0] adcsf_addr_t;
  typedef logic [`ADCSF_NEVT-1:0] adcsf_evt_t;
  typedef enum logic {ADCSF_ST_IDLE, ADCSF_ST_DONE} adcsf_apb_st_t;
endpackage

// ### core/adcsf_apb_slave.sv
`timescale 1ns/1ps
module adcsf_apb_slave (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_rdata,
  input wire logic i_addr_ok,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output logic o_rd_stb,
  output logic o_wr_stb
);
  import adcsf_pkg::*;

  adcsf_apb_st_t state_r;
  adcsf_apb_st_t state_nxt;

  // ****************************************
  // Access sequencing
  // ****************************************
  // Next state: one wait cycle, then ready
  always_comb begin
    case (state_r)
      ADCSF_ST_IDLE: begin
        state_nxt = (i_psel && i_penable) ? ADCSF_ST_DONE : ADCSF_ST_IDLE;
      end
      ADCSF_ST_DONE: begin
        state_nxt = ADCSF_ST_IDLE;
      end
      default: begin
        state_nxt = ADCSF_ST_IDLE;
      end
    endcase
  end

  // Reads act when data is captured, writes on the completing edge
  assign o_rd_stb = i_psel && i_penable && !i_pwrite && (state_r == ADCSF_ST_IDLE);
  assign o_wr_stb = i_psel && i_penable && i_pwrite && (state_r == ADCSF_ST_DONE);

  // State register
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ADCSF_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Ready and error answer
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= (state_nxt == ADCSF_ST_DONE);
      o_pslverr <= (state_nxt == ADCSF_ST_DONE) && !i_addr_ok;
    end
  end

  // Read data capture, same edge as read side effects
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
    end else if (o_rd_stb) begin
      o_prdata <= i_addr_ok ? i_rdata : 32'h0000_0000;
    end
  end
endmodule

// ### core/adcsf_irq.sv
`timescale 1ns/1ps
`include "adcsf_defs.svh"
module adcsf_irq (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire adcsf_pkg::adcsf_evt_t i_evt,
  input wire logic i_clr_wr,
  input wire logic i_mask_wr,
  input wire adcsf_pkg::adcsf_evt_t i_wdata,
  output adcsf_pkg::adcsf_evt_t o_status,
  output adcsf_pkg::adcsf_evt_t o_mask,
  output logic o_irq
);
  import adcsf_pkg::*;

  adcsf_evt_t status_nxt;
  adcsf_evt_t mask_nxt;

  // Write one clears, a new event wins over the clear
  always_comb begin
    status_nxt = (o_status & ~(i_clr_wr ? i_wdata : '0)) | i_evt;
    mask_nxt = i_mask_wr ? i_wdata : o_mask;
  end

  // Sticky status
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_status <= '0;
    end else begin
      o_status <= status_nxt;
    end
  end

  // Mask
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mask <= `ADCSF_MASK_RST;
    end else begin
      o_mask <= mask_nxt;
    end
  end

  // Level interrupt aligned with the status
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status_nxt & mask_nxt);
    end
  end
endmodule

// ### core/adcsf_top.sv
// Behaviour
// - Data ready clears only on a read of the last result, never on a channel result read.
// - Data ready rises only when new conversion data is actually stored.
// - An end of conversion on an enabled channel sets data ready despite another channel read.
// - Storing a result raises data ready even when another channel is disabled that cycle.
// - A status read with an end of conversion still sets or clears the global overrun.
// - A store while the channel done flag or data ready stands sets the global overrun; either one alone is enough.
// - A store on a channel whose done flag stands sets its overrun and the global overrun.
// - A status read clears every channel overrun except one set by an overrun store in the same cycle.
// - A done flag sets at its store and clears on its own result read or on a last result read while the last result is from its channel.
// - A channel disabled during its conversion gets no done flag when that conversion ends.
// - A channel result read clears only that channel's done flag.
// - Sleep selected while idle takes effect only after the next conversion completes.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "adcsf_defs.svh"
module adcsf_top (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire adcsf_pkg::adcsf_addr_t i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_eoc_valid,
  input wire adcsf_pkg::adcsf_chan_t i_eoc_chan,
  input wire adcsf_pkg::adcsf_data_t i_eoc_data,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output logic o_irq,
  output logic o_conv_start,
  output logic o_sleep
);
  import adcsf_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  adcsf_chmask_t en_r;
  adcsf_chmask_t eoc_r;
  adcsf_chmask_t chovr_r;
  logic ready_r;
  logic glovr_r;
  logic sleep_sel_r;
  adcsf_data_t cdr_r [`ADCSF_NCH];
  adcsf_data_t last_r;
  adcsf_chan_t last_ch_r;
  adcsf_chmask_t eoc_nxt;
  adcsf_chmask_t chovr_nxt;
  logic ready_nxt;
  logic glovr_nxt;
  logic rd_stb;
  logic wr_stb;
  logic rd_sr;
  logic rd_lcdr;
  adcsf_chmask_t rd_cdr;
  adcsf_chmask_t addr_hit;
  logic store;
  logic ovr_hit;
  logic addr_ok;
  logic [31:0] rdata;
  adcsf_evt_t irq_evt;
  adcsf_evt_t irq_status;
  adcsf_evt_t irq_mask;

  // ****************************************
  // Decoding
  // ****************************************
  // One-hot channel result hit for an address
  function automatic adcsf_chmask_t cdr_hit(input adcsf_addr_t addr);
    adcsf_chmask_t hit;
    hit = '0;
    for (int i = 0; i < `ADCSF_NCH; i++) begin
      if (addr == `ADCSF_CDR_BASE_OFS + 8'(4 * i)) begin
        hit[i] = 1'b1;
      end
    end
    return hit;
  endfunction

  // Read side-effect strobes
  assign rd_sr = rd_stb && (i_paddr == `ADCSF_STAT_OFS);
  assign rd_lcdr = rd_stb && (i_paddr == `ADCSF_LAST_OFS);
  assign addr_hit = cdr_hit(i_paddr);
  assign rd_cdr = rd_stb ? addr_hit : '0;

  // Data is stored only for a channel still enabled at its end
  assign store = i_eoc_valid && en_r[i_eoc_chan];
  assign ovr_hit = store && eoc_r[i_eoc_chan];

  // ****************************************
  // Bus slave and read mux
  // ****************************************
  // Register read data
  always_comb begin
    rdata = 32'h0000_0000;
    addr_ok = 1'b1;
    case (i_paddr)
      `ADCSF_CTRL_OFS: rdata = 32'h0000_0000;
      `ADCSF_MODE_OFS: rdata[`ADCSF_MODE_SLEEP_BIT] = sleep_sel_r;
      `ADCSF_CHEN_OFS, `ADCSF_CHDIS_OFS: rdata = 32'h0000_0000;
      `ADCSF_CHSTAT_OFS: rdata[`ADCSF_NCH-1:0] = en_r;
      `ADCSF_STAT_OFS: begin
        rdata[`ADCSF_NCH-1:0] = eoc_r;
        rdata[`ADCSF_STAT_CHOVR_LSB +: `ADCSF_NCH] = chovr_r;
        rdata[`ADCSF_STAT_READY_BIT] = ready_r;
        rdata[`ADCSF_STAT_GLOVR_BIT] = glovr_r;
      end
      `ADCSF_LAST_OFS: begin
        rdata[`ADCSF_DW-1:0] = last_r;
        rdata[`ADCSF_LAST_CH_LSB +: `ADCSF_CHW] = last_ch_r;
      end
      `ADCSF_IRQ_STAT_OFS: rdata[`ADCSF_NEVT-1:0] = irq_status;
      `ADCSF_IRQ_MASK_OFS: rdata[`ADCSF_NEVT-1:0] = irq_mask;
      default: begin
        addr_ok = |addr_hit;
        for (int i = 0; i < `ADCSF_NCH; i++) begin
          if (addr_hit[i]) begin
            rdata[`ADCSF_DW-1:0] = cdr_r[i];
          end
        end
      end
    endcase
  end

  // APB slave
  adcsf_apb_slave u_apb (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_rdata(rdata),
    .i_addr_ok(addr_ok),
    .o_pready(o_pready),
    .o_prdata(o_prdata),
    .o_pslverr(o_pslverr),
    .o_rd_stb(rd_stb),
    .o_wr_stb(wr_stb)
  );

  // ****************************************
  // Configuration
  // ****************************************
  // Channel enable set and clear writes
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_r <= `ADCSF_CHEN_RST;
    end else if (wr_stb && i_paddr == `ADCSF_CHEN_OFS) begin
      en_r <= en_r | i_pwdata[`ADCSF_NCH-1:0];
    end else if (wr_stb && i_paddr == `ADCSF_CHDIS_OFS) begin
      en_r <= en_r & ~i_pwdata[`ADCSF_NCH-1:0];
    end
  end

  // Sleep select and start pulse
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sleep_sel_r <= 1'b0;
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= wr_stb && (i_paddr == `ADCSF_CTRL_OFS)
                      && i_pwdata[`ADCSF_CTRL_START_BIT];
      if (wr_stb && i_paddr == `ADCSF_MODE_OFS) begin
        sleep_sel_r <= i_pwdata[`ADCSF_MODE_SLEEP_BIT];
      end
    end
  end

  // Sleep entered only at a conversion end
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sleep <= 1'b0;
    end else if (!sleep_sel_r) begin
      o_sleep <= 1'b0;
    end else if (i_eoc_valid) begin
      o_sleep <= 1'b1;
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  // Next flag values, sets win over read clears
  always_comb begin
    eoc_nxt = eoc_r & ~rd_cdr;
    if (rd_lcdr) begin
      eoc_nxt[last_ch_r] = 1'b0;
    end
    chovr_nxt = rd_sr ? '0 : chovr_r;
    ready_nxt = rd_lcdr ? 1'b0 : ready_r;
    glovr_nxt = rd_sr ? 1'b0 : glovr_r;
    if (store) begin
      eoc_nxt[i_eoc_chan] = 1'b1;
      ready_nxt = 1'b1;
      if (ovr_hit) begin
        chovr_nxt[i_eoc_chan] = 1'b1;
      end
      if (ovr_hit || ready_r) begin
        glovr_nxt = 1'b1;
      end
    end
  end

  // Flag registers
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      eoc_r <= '0;
      chovr_r <= '0;
      ready_r <= 1'b0;
      glovr_r <= 1'b0;
    end else begin
      eoc_r <= eoc_nxt;
      chovr_r <= chovr_nxt;
      ready_r <= ready_nxt;
      glovr_r <= glovr_nxt;
    end
  end

  // Result storage, channel and last
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < `ADCSF_NCH; i++) begin
        cdr_r[i] <= '0;
      end
      last_r <= '0;
      last_ch_r <= '0;
    end else if (store) begin
      cdr_r[i_eoc_chan] <= i_eoc_data;
      last_r <= i_eoc_data;
      last_ch_r <= i_eoc_chan;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign irq_evt[`ADCSF_EVT_EOC_BIT] = store;
  assign irq_evt[`ADCSF_EVT_READY_BIT] = store && !ready_r;
  assign irq_evt[`ADCSF_EVT_CHOVR_BIT] = ovr_hit;
  assign irq_evt[`ADCSF_EVT_GLOVR_BIT] = store && (ovr_hit || ready_r);

  adcsf_irq u_irq (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_evt(irq_evt),
    .i_clr_wr(wr_stb && i_paddr == `ADCSF_IRQ_STAT_OFS),
    .i_mask_wr(wr_stb && i_paddr == `ADCSF_IRQ_MASK_OFS),
    .i_wdata(i_pwdata[`ADCSF_NEVT-1:0]),
    .o_status(irq_status),
    .o_mask(irq_mask),
    .o_irq(o_irq)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_store_with_cdr_read;
    store ##0 (|rd_cdr);
  endsequence

  sequence s_sleep_armed;
    sleep_sel_r && !o_sleep ##1 sleep_sel_r && i_eoc_valid;
  endsequence

  property p_ready_clear_cause;
    $fell(ready_r) |-> $past(rd_lcdr);
  endproperty
  a_ready_clear_cause: assert property (p_ready_clear_cause) else $error("data ready cleared badly");

  property p_ready_rise_cause;
    $rose(ready_r) |-> $past(store);
  endproperty
  a_ready_rise_cause: assert property (p_ready_rise_cause) else $error("data ready without store");

  property p_ready_cdr_read;
    s_store_with_cdr_read |=> ready_r && eoc_r[$past(i_eoc_chan)];
  endproperty
  a_ready_cdr_read: assert property (p_ready_cdr_read) else $error("data ready lost on read");

  property p_ready_set_wins;
    store && rd_lcdr |=> ready_r;
  endproperty
  a_ready_set_wins: assert property (p_ready_set_wins) else $error("set lost to clear");

  property p_glovr_sr_read;
    rd_sr |=> glovr_r == $past(store && (ready_r || eoc_r[i_eoc_chan]));
  endproperty
  a_glovr_sr_read: assert property (p_glovr_sr_read) else $error("global overrun wrong");

  property p_glovr_overrun;
    store && ready_r |=> glovr_r [*1] ##1 (glovr_r || $past(rd_sr));
  endproperty
  a_glovr_overrun: assert property (p_glovr_overrun) else $error("global overrun missed");

  property p_chovr_set;
    ovr_hit |=> chovr_r[$past(i_eoc_chan)] && glovr_r;
  endproperty
  a_chovr_set: assert property (p_chovr_set) else $error("overrun not set");

  property p_chovr_sr_clear;
    rd_sr && !ovr_hit |=> chovr_r == '0;
  endproperty
  a_chovr_sr_clear: assert property (p_chovr_sr_clear) else $error("overrun not cleared");

  property p_eoc_disabled;
    i_eoc_valid && !en_r[i_eoc_chan] && !eoc_r[i_eoc_chan]
      |=> !eoc_r[$past(i_eoc_chan)];
  endproperty
  a_eoc_disabled: assert property (p_eoc_disabled) else $error("done on disabled channel");

  property p_eoc_only_own;
    (|rd_cdr) && !store |=> eoc_r == ($past(eoc_r) & ~$past(rd_cdr));
  endproperty
  a_eoc_only_own: assert property (p_eoc_only_own) else $error("wrong done flag cleared");

  property p_sleep_entry;
    s_sleep_armed |=> o_sleep;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

  property p_sleep_idle;
    $rose(o_sleep) |-> $past(i_eoc_valid) && $past(sleep_sel_r);
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("sleep without conversion");
endmodule

// ### bench/adcsf_conv_model.sv
`timescale 1ns/1ps
module adcsf_conv_model (
  input wire logic i_sys_clk,
  input wire logic i_conv_start,
  output logic o_eoc_valid,
  output adcsf_pkg::adcsf_chan_t o_eoc_chan,
  output adcsf_pkg::adcsf_data_t o_eoc_data
);
  import adcsf_pkg::*;

  // Cycles from a start pulse to its end of conversion
  int lat = 0;

  initial begin
    o_eoc_valid = 1'b0;
    o_eoc_chan = '0;
    o_eoc_data = '0;
  end

  // One end-of-conversion pulse; lines invert once it is over
  task automatic fire(input adcsf_chan_t ch, input adcsf_data_t dd);
    o_eoc_valid <= 1'b1;
    o_eoc_chan <= ch;
    o_eoc_data <= dd;
    @(posedge i_sys_clk);
    o_eoc_valid <= 1'b0;
    o_eoc_chan <= ~ch;
    o_eoc_data <= ~dd;
  endtask

  // A start pulse launches one conversion on the top channel
  always @(posedge i_sys_clk) begin
    if (i_conv_start === 1'b1) begin
      repeat (lat) @(posedge i_sys_clk);
      fire(3'h7, 10'($urandom));
    end
  end
endmodule

// ### bench/adc_status_flag_logic_tb_top.sv
`timescale 1ns/1ps
module adc_status_flag_logic_tb_top;
  import adcsf_pkg::*;

  typedef struct {logic [31:0] v; logic [31:0] m; logic e;} adcsf_note_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  adcsf_addr_t paddr = '0;
  logic [31:0] pwdata = '0;
  logic pready, pslverr, irq, cstart, sleep, eoc_v;
  logic [31:0] prdata;
  adcsf_chan_t eoc_ch;
  adcsf_data_t eoc_d;
  adcsf_data_t d[8];
  adcsf_note_t q[$];
  adcsf_note_t note;
  int error_cnt = 0;
  int n_compared = 0;

  always #12.5 clk = ~clk;

  adcsf_top dut_u (.i_sys_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_eoc_valid(eoc_v),
    .i_eoc_chan(eoc_ch), .i_eoc_data(eoc_d), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .o_irq(irq), .o_conv_start(cstart), .o_sleep(sleep));

  adcsf_conv_model conv_u (.i_sys_clk(clk), .i_conv_start(cstart), .o_eoc_valid(eoc_v),
    .o_eoc_chan(eoc_ch), .o_eoc_data(eoc_d));

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    chk(32'(q.size()), 32'h0);
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Full transfer, entered right after a rising edge
  task automatic apb(input adcsf_addr_t a, input logic w, input logic [31:0] wd,
    input logic [31:0] v, input logic [31:0] m, input logic e);
    q.push_back('{v, m, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never re-drives psel in this time step
    @(posedge clk);
  endtask

  task automatic rd(input adcsf_addr_t a, input logic [31:0] v, input logic [31:0] m);
    apb(a, 1'b0, 32'h0, v, m, 1'b0);
  endtask

  task automatic wr(input adcsf_addr_t a, input logic [31:0] wd);
    apb(a, 1'b1, wd, 32'h0, 32'h0, 1'b0);
  endtask

  // Transfer with an end of conversion at its effect edge
  task automatic co(input adcsf_addr_t a, input logic w, input logic [31:0] wd,
    input logic [31:0] v, input logic [31:0] m, input adcsf_chan_t ch, input adcsf_data_t dd);
    fork
      apb(a, w, wd, v, m, 1'b0);
      begin
        repeat (w ? 2 : 1) @(posedge clk);
        conv_u.fire(ch, dd);
      end
    join
  endtask

  function automatic logic [31:0] lastv(input adcsf_chan_t ch, input adcsf_data_t dd);
    return {13'h0, ch, 6'h0, dd};
  endfunction

  task automatic irq_is(input logic x);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'(x));
  endtask

  // Completed transfers against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && q.size() > 0) begin
      note = q.pop_front();
      chk(32'(pslverr), 32'(note.e));
      chk(prdata & note.m, note.v);
    end
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(83));
    foreach (d[i]) d[i] = 10'($urandom);
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(8'h18, 32'h0, 32'hffffffff);
    rd(8'h1c, 32'h0, 32'hffffffff);
    rd(8'h2c, 32'h0, 32'hffffffff);
    apb(8'h3c, 1'b0, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    wr(8'h10, 32'hff);
    rd(8'h18, 32'hff, 32'hff);
    conv_u.fire(3'h1, d[1]);
    @(posedge clk);
    conv_u.fire(3'h2, d[2]);
    rd(8'h48, 32'(d[2]), 32'h3ff);
    rd(8'h1c, 32'h00030002, 32'h3ffff);
    rd(8'h20, lastv(3'h2, d[2]), 32'h7ffff);
    rd(8'h1c, 32'h00000002, 32'h3ffff);
    conv_u.fire(3'h2, d[4]);
    co(8'h44, 1'b0, 32'h0, 32'(d[1]), 32'h3ff, 3'h3, d[3]);
    rd(8'h1c, 32'h0003000c, 32'h3ffff);
    rd(8'h20, lastv(3'h3, d[3]), 32'h7ffff);
    co(8'h14, 1'b1, 32'h40, 32'h0, 32'h0, 3'h2, d[5]);
    rd(8'h1c, 32'h00030404, 32'h3ffff);
    rd(8'h18, 32'hbf, 32'hff);
    conv_u.fire(3'h2, d[6]);
    rd(8'h48, 32'(d[6]), 32'h3ff);
    co(8'h1c, 1'b0, 32'h0, 32'h00030400, 32'h3ffff, 3'h2, d[7]);
    rd(8'h1c, 32'h00030004, 32'h3ffff);
    rd(8'h1c, 32'h00010004, 32'h3ffff);
    rd(8'h20, lastv(3'h2, d[7]), 32'h7ffff);
    co(8'h40, 1'b0, 32'h0, 32'h0, 32'h0, 3'h6, d[0]);
    rd(8'h1c, 32'h0, 32'h3ffff);
    conv_u.fire(3'h0, d[0]);
    co(8'h20, 1'b0, 32'h0, lastv(3'h0, d[0]), 32'h7ffff, 3'h6, d[1]);
    rd(8'h1c, 32'h0, 32'h3ffff);
    co(8'h20, 1'b0, 32'h0, lastv(3'h0, d[0]), 32'h7ffff, 3'h5, d[3]);
    rd(8'h1c, 32'h00010020, 32'h3ffff);
    rd(8'h28, 32'hf, 32'hf);
    wr(8'h2c, 32'h1);
    irq_is(1'b1);
    wr(8'h28, 32'hf);
    irq_is(1'b0);
    rd(8'h28, 32'h0, 32'hf);
    conv_u.fire(3'h1, d[2]);
    irq_is(1'b1);
    wr(8'h2c, 32'h0);
    irq_is(1'b0);
    wr(8'h04, 32'h1);
    rd(8'h04, 32'h1, 32'h1);
    repeat (3) @(posedge clk);
    chk(32'(sleep), 32'h0);
    conv_u.lat = 5;
    wr(8'h00, 32'h1);
    repeat (10) @(posedge clk);
    chk(32'(sleep), 32'h1);
    wr(8'h04, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(sleep), 32'h0);
    wrap_up();
  end
endmodule
